//--- qdp_bus_master.sv
`timescale 1ns/1ns
// two-wire master, clock stands high between frames
module qdp_bus_master (
  output reg  scl,
  output reg  sda_low,
  input  wire sda
);
  reg r;
  integer k;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit, data set while clock low, sampled mid high
  task bit_io(input b, output v); begin
    sda_low = ~b;
    #40 scl = 1'b1;
    #40 v = sda;
    #40 scl = 1'b0;
    #40;
  end endtask
  task bstart; begin
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
  end endtask
  task bstop; begin
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  end endtask
  // msb first, then acknowledge bit
  task wbyte(input [7:0] d, output ack); begin
    for (k = 7; k >= 0; k = k - 1) bit_io(d[k], r);
    bit_io(1'b1, r);
    ack = !r;
  end endtask
  task rbyte(input last, output [7:0] d); begin
    for (k = 7; k >= 0; k = k - 1) bit_io(1'b1, d[k]);
    bit_io(last, r);
  end endtask
endmodule // qdp_bus_master

//--- qdp_defs.vh
`ifndef QDP_DEFS_VH
`define QDP_DEFS_VH
// device type identifier (arbitrary value)
`define QDP_DEV_TYPE      4'h9
// opcodes, upper nibble of the instruction byte
`define QDP_OP_RD_WIPER   4'h9
`define QDP_OP_WR_WIPER   4'ha
`define QDP_OP_RD_SET     4'hb
`define QDP_OP_WR_SET     4'hc
`define QDP_OP_XFR_TO_W   4'hd
`define QDP_OP_XFR_TO_S   4'he
// nonvolatile write time in ms and in cycles of the 50 MHz clock
`define QDP_NV_WRITE_MS   10
`define QDP_CLK_KHZ       50000
`define QDP_NV_CYCLES     (`QDP_NV_WRITE_MS * `QDP_CLK_KHZ)
// reset value of every setting register
`define QDP_SET_RESET     8'h80
`endif

//--- qdp_pot_slave.v
`timescale 1ns/1ns
`include "qdp_defs.vh"
// Summary of operation
// R1: four channels, each one wiper register and four setting registers, all accessible
// R2: wiper register value alone selects one of 256 taps
// R3: at power-up each wiper loads its channel's slot zero setting
// R4: incoming data bits sampled on serial clock rising edge
// R5: outgoing data changes only after serial clock falling edge
// R6: data line only pulled low, otherwise released
// R7: low four address bits come from four straps and must match
// R8: system gives every device a unique strap address, sixteen at most
// R9: master sends address, then instruction with pointers, then data
// R10: write lock low blocks every setting register write
// R11: first byte needs fixed type in upper nibble and straps below
// R12: acknowledge valid address, instruction bytes, and write data bytes
// R13: during nonvolatile write ignore bus and withhold address acknowledge
// R14: bytes travel msb first, eight bits then acknowledge
module qdp_pot_slave #(
  parameter NV_CYCLES = `QDP_NV_CYCLES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        scl,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_n,
  input  wire        addr_strap_0,
  input  wire        addr_strap_1,
  input  wire        addr_strap_2,
  input  wire        addr_strap_3,
  input  wire        write_lock_n,
  output wire [7:0]  wiper_ch0,
  output wire [7:0]  wiper_ch1,
  output wire [7:0]  wiper_ch2,
  output wire [7:0]  wiper_ch3,
  output wire        nv_busy
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_INST = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_RDAT = 3'd4;
  localparam ST_SKIP = 3'd5;

  reg  [7:0]  wiper_position_reg [0:3];
  reg  [7:0]  nonvolatile_setting_reg [0:15];
  reg  [2:0]  scl_s_q;
  reg  [2:0]  sda_s_q;
  reg  [5:0]  lock_s_q;
  reg  [2:0]  st_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  tx_q;
  reg  [3:0]  inst_q;
  reg  [3:0]  ptr_q;
  reg         ack_q;
  reg         drv_q;
  reg         boot_q;
  reg  [1:0]  boot_ch_q;
  reg  [31:0] nv_cnt_q;
  reg  [3:0]  strap_q;
  reg  [7:0]  strap_s_q;
  reg         nv_pend_q;
  integer     i;

  wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
  wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
  wire sda_now  = sda_s_q[1];
  wire start_c  = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  wire stop_c   = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];
  wire busy     = (nv_cnt_q != 32'h0);
  wire [7:0] rx_byte = {sh_q[6:0], sda_now};

  // read data selected by the pointer
  function [7:0] qdp_rd;
    input [3:0] op;
    input [3:0] p;
    begin
      if (op == `QDP_OP_RD_WIPER)
        qdp_rd = wiper_position_reg[p[1:0]];
      else
        qdp_rd = nonvolatile_setting_reg[{p[1:0], p[3:2]}];
    end
  endfunction

  // byte that a read returns, for the pointer held
  wire [7:0] rd_now = qdp_rd(inst_q, ptr_q);

  assign sda_o    = 1'b0;                       // see R6
  assign sda_oe_n = ~drv_q;                     // see R6
  assign nv_busy  = busy;
  assign wiper_ch0 = wiper_position_reg[0];     // see R2
  assign wiper_ch1 = wiper_position_reg[1];
  assign wiper_ch2 = wiper_position_reg[2];
  assign wiper_ch3 = wiper_position_reg[3];

  // two-stage synchronisers and edge history, six stages on the write lock
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_s_q  <= 3'h7;
      sda_s_q  <= 3'h7;
      lock_s_q <= 6'h0;
      strap_s_q <= 8'h00;
    end else begin
      scl_s_q  <= {scl_s_q[1:0], scl};
      sda_s_q  <= {sda_s_q[1:0], sda_i};
      lock_s_q <= {lock_s_q[4:0], write_lock_n};
      strap_s_q <= {strap_s_q[3:0], addr_strap_3, addr_strap_2, addr_strap_1, addr_strap_0};
    end
  end

  // protocol engine, registers and power-up recall
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      inst_q    <= 4'h0;
      ptr_q     <= 4'h0;
      ack_q     <= 1'b0;
      drv_q     <= 1'b0;
      boot_q    <= 1'b1;
      boot_ch_q <= 2'h0;
      nv_cnt_q  <= 32'h0;
      strap_q   <= 4'h0;
      nv_pend_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        wiper_position_reg[i] <= 8'h00;
      for (i = 0; i < 16; i = i + 1)
        nonvolatile_setting_reg[i] <= `QDP_SET_RESET;
    end else if (boot_q) begin
      // recall slot zero into each wiper, one channel per cycle
      wiper_position_reg[boot_ch_q] <= nonvolatile_setting_reg[{boot_ch_q, 2'b00}]; // see R3
      strap_q   <= strap_s_q[7:4];                 // see R7
      boot_ch_q <= boot_ch_q + 2'h1;
      if (boot_ch_q == 2'h3)
        boot_q <= 1'b0;
    end else if (busy) begin
      nv_cnt_q <= nv_cnt_q - 32'h1;              // see R13
      st_q     <= ST_IDLE;
      drv_q    <= 1'b0;
    end else if (start_c) begin
      st_q  <= ST_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (stop_c) begin
      st_q  <= ST_IDLE;
      drv_q <= 1'b0;
      // a write cut short by stop still starts its timer
      if (nv_pend_q) begin
        nv_cnt_q  <= NV_CYCLES;                  // see R13
        nv_pend_q <= 1'b0;
      end
    end else if (st_q != ST_IDLE) begin
      // skip state still counts bits so a held acknowledge is released
      if (scl_rise) begin
        if (ack_q) begin
          // ninth clock: master acknowledge matters only when reading
          if (st_q == ST_RDAT && sda_now)
            st_q <= ST_SKIP;
        end else begin
          sh_q  <= rx_byte;                      // see R4, R14
          bit_q <= bit_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          bit_q <= 4'h0;
          drv_q <= 1'b0;
          // nonvolatile write starts once the acknowledge is over
          if (nv_pend_q) begin
            nv_cnt_q  <= NV_CYCLES;              // see R13
            nv_pend_q <= 1'b0;
          end
          if (st_q == ST_RDAT) begin
            drv_q <= ~rd_now[7];                 // see R5
            tx_q  <= {rd_now[6:0], 1'b0};        // reload for next byte
          end
        end else if (bit_q == 4'h8) begin
          ack_q <= 1'b1;
          case (st_q)
            ST_ADDR: begin
              if (sh_q == {`QDP_DEV_TYPE, strap_q}) begin // see R11, R7
                drv_q <= 1'b1;                   // see R12
                st_q  <= ST_INST;
              end else begin
                st_q  <= ST_SKIP;
              end
            end
            ST_INST: begin
              drv_q  <= 1'b1;                    // see R12, R9
              inst_q <= sh_q[7:4];
              ptr_q  <= sh_q[3:0];
              case (sh_q[7:4])
                `QDP_OP_RD_WIPER, `QDP_OP_RD_SET: st_q <= ST_RDAT;
                `QDP_OP_WR_WIPER, `QDP_OP_WR_SET: st_q <= ST_WDAT;
                `QDP_OP_XFR_TO_W: begin
                  wiper_position_reg[sh_q[1:0]] <=
                    nonvolatile_setting_reg[{sh_q[1:0], sh_q[3:2]}];
                  st_q <= ST_SKIP;
                end
                `QDP_OP_XFR_TO_S: begin
                  if (lock_s_q[5]) begin          // see R10
                    nonvolatile_setting_reg[{sh_q[1:0], sh_q[3:2]}] <=
                      wiper_position_reg[sh_q[1:0]];
                    nv_pend_q <= 1'b1;           // see R13
                  end
                  st_q <= ST_SKIP;
                end
                default: st_q <= ST_SKIP;
              endcase
            end
            ST_WDAT: begin
              drv_q <= 1'b1;                     // see R12
              if (inst_q == `QDP_OP_WR_WIPER) begin
                wiper_position_reg[ptr_q[1:0]] <= sh_q;
              end else if (lock_s_q[5]) begin     // see R10
                nonvolatile_setting_reg[{ptr_q[1:0], ptr_q[3:2]}] <= sh_q; // see R1
                nv_pend_q <= 1'b1;               // see R13
              end
              st_q <= ST_SKIP;
            end
            default: drv_q <= 1'b0;
          endcase
          if (st_q == ST_INST && (sh_q[7:4] == `QDP_OP_RD_WIPER ||
              sh_q[7:4] == `QDP_OP_RD_SET)) begin
            tx_q <= qdp_rd(sh_q[7:4], sh_q[3:0]);
          end
        end else if (st_q == ST_RDAT) begin
          drv_q <= ~tx_q[7];                     // see R5, R14
          tx_q  <= {tx_q[6:0], 1'b0};
          if (bit_q == 4'h7)
            drv_q <= ~tx_q[7];
        end
      end
    end
  end
endmodule // qdp_pot_slave

//--- qdp_pot_slave_properties.sv
`timescale 1ns/1ns
// protocol checks on the slave's own outputs
module qdp_pot_slave_properties #(
  parameter NV_CYCLES = 400
) (
  input wire       clk,
  input wire       rstn,
  input wire       scl,
  input wire       sda_o,
  input wire       sda_oe_n,
  input wire       write_lock_n,
  input wire [7:0] wiper_ch0,
  input wire       nv_busy
);
  localparam int NVMAX = NV_CYCLES + 8;
  // line is only ever pulled low
  a_drive_low: assert property (@(posedge clk) !sda_oe_n |-> !sda_o)
    else $error("data driven high");
  a_reset_idle: assert property (@(posedge clk) !rstn |-> sda_oe_n && !nv_busy)
    else $error("busy or driving in reset");
  a_recall_seen: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> ##[0:6] wiper_ch0 == 8'h80) else $error("no recall");
  a_busy_quiet: assert property (@(posedge clk) disable iff (!rstn) nv_busy |-> sda_oe_n)
    else $error("answer while busy");
  a_busy_wiper: assert property (@(posedge clk) disable iff (!rstn) nv_busy |-> $stable(wiper_ch0))
    else $error("wiper moved while busy");
  a_lock_blocks: assert property (@(posedge clk) disable iff (!rstn) $rose(nv_busy) |-> write_lock_n)
    else $error("write under lock");
  a_change_low: assert property (@(posedge clk) disable iff (!rstn) $changed(sda_oe_n) |-> !scl)
    else $error("data moved with clock high");
  a_ack_stands: assert property (@(posedge clk) disable iff (!rstn) $fell(sda_oe_n) |=> !sda_oe_n [*4])
    else $error("low bit too short");
  a_busy_len: assert property (@(posedge clk) disable iff (!rstn)
    $rose(nv_busy) |-> nv_busy [*8] ##[1:NVMAX] !nv_busy) else $error("busy length");
endmodule // qdp_pot_slave_properties
bind qdp_pot_slave qdp_pot_slave_properties #(.NV_CYCLES(NV_CYCLES)) chk_i (.clk(clk), .rstn(rstn),
  .scl(scl), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_lock_n(write_lock_n),
  .wiper_ch0(wiper_ch0), .nv_busy(nv_busy));

//--- tb.sv
`timescale 1ns/1ns
module tb;
  reg         clk, rstn, write_lock_n, ack;
  wire        scl, sda_low, sda_o, sda_oe_n, nv_busy;
  wire [31:0] wall;
  reg  [7:0]  rd;
  integer     n_fail, n_compared, i;
  wire        sda = ~sda_low & (sda_oe_n | sda_o); // pull-up wired and
  qdp_bus_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
  qdp_pot_slave #(.NV_CYCLES(400)) dut (.clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_strap_0(1'b0), .addr_strap_1(1'b1),
    .addr_strap_2(1'b1), .addr_strap_3(1'b0), .write_lock_n(write_lock_n),
    .wiper_ch0(wall[7:0]), .wiper_ch1(wall[15:8]), .wiper_ch2(wall[23:16]),
    .wiper_ch3(wall[31:24]), .nv_busy(nv_busy));
  task chk(input string what, input [7:0] exp, input [7:0] got); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s exp %h got %h", what, exp, got);
    end
  end endtask
  // id, instruction, optional data, every acknowledge checked
  task frame(input [7:0] ins, input [7:0] d, input wd); begin
    m.bstart;
    m.wbyte(8'h96, ack);
    chk("id ack", 8'h01, {7'h0, ack});
    m.wbyte(ins, ack);
    chk("ins ack", 8'h01, {7'h0, ack});
    if (wd) m.wbyte(d, ack);
    if (wd) chk("data ack", 8'h01, {7'h0, ack});
    m.bstop;
    repeat (4) @(posedge clk);
    #1;
  end endtask
  task t_wipers; begin
    for (i = 0; i < 4; i = i + 1) begin
      chk("recall", 8'h80, wall[8*i +: 8]);
      frame(8'ha0 | i[7:0], 8'h3c + i[7:0], 1'b1);
      chk("wiper", 8'h3c + i[7:0], wall[8*i +: 8]);
    end
  end endtask
  task t_read; begin
    m.bstart;
    m.wbyte(8'h96, ack);
    m.wbyte(8'h91, ack);
    m.rbyte(1'b1, rd);
    m.bstop;
    chk("read", 8'h3d, rd);
  end endtask
  // wrong strap, then wrong type
  task t_bad_id; begin
    for (i = 0; i < 2; i = i + 1) begin
      m.bstart;
      m.wbyte(i ? 8'h36 : 8'h97, ack);
      m.bstop;
      chk("bad id", 8'h00, {7'h0, ack});
    end
  end endtask
  task t_settings; begin
    write_lock_n = 1'b0;
    frame(8'hc6, 8'h55, 1'b1);
    chk("lock busy", 8'h00, {7'h0, nv_busy});
    write_lock_n = 1'b1;
    frame(8'hd6, 8'h00, 1'b0);
    chk("lock kept", 8'h80, wall[23:16]);
    frame(8'hc6, 8'h55, 1'b1);
    chk("busy", 8'h01, {7'h0, nv_busy});
    m.bstart;
    m.wbyte(8'h96, ack);
    m.bstop;
    chk("busy ack", 8'h00, {7'h0, ack});
    for (i = 0; i < 600 && nv_busy !== 1'b0; i = i + 1) @(posedge clk);
    #1;
    chk("busy end", 8'h00, {7'h0, nv_busy});
    frame(8'hd6, 8'h00, 1'b0);
    chk("xfer", 8'h55, wall[23:16]);
  end endtask
  task close_out; begin
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  end endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    n_compared = 0;
    rstn = 1'b0;
    write_lock_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    t_wipers;
    t_read;
    t_bad_id;
    t_settings;
    close_out;
  end
  // watchdog
  initial begin
    #400000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule // tb
